// ===== hw/pcpl_map.vh
// Constants for the pulse command position loop
`ifndef PCPL_MAP_VH
`define PCPL_MAP_VH
`define PCPL_CLK_HZ        25000000
`define PCPL_POS_LOOP_HZ   2500
`define PCPL_VEL_LOOP_HZ   5000
`define PCPL_POS_DIV       (`PCPL_CLK_HZ / `PCPL_POS_LOOP_HZ)
`define PCPL_VEL_DIV       (`PCPL_CLK_HZ / `PCPL_VEL_LOOP_HZ)
`define PCPL_MODE_STEP_DIR 1'b0
`define PCPL_MODE_DUAL     1'b1
`define PCPL_POS_W         32
`define PCPL_GAIN_W        16
`define PCPL_VEL_W         32
`define PCPL_SPD_W         24
`endif

// ===== hw/pcpl_quad_decoder.v
// Quadrature encoder decoder, four counts per line
`timescale 1ns/1ns
`default_nettype none
module pcpl_quad_decoder #(
  parameter POS_W = 32
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             enc_a,
  input  wire             enc_b,
  output reg  [POS_W-1:0] actual_pos_ff,
  output reg              edge_ff
);
  reg [1:0] a_sync_ff;
  reg [1:0] b_sync_ff;
  reg       a_old_ff;
  reg       b_old_ff;
  wire      a_now = a_sync_ff[1];
  wire      b_now = b_sync_ff[1];
  wire      moved = (a_now ^ a_old_ff) | (b_now ^ b_old_ff);
  // Forward when the new A differs from the old B
  wire      fwd   = a_now ^ b_old_ff;

  // ==========================================================
  // Sync and decode; every edge of A or B is one count
  always @(posedge clk) begin
    if (reset) begin
      a_sync_ff     <= 2'b00;
      b_sync_ff     <= 2'b00;
      a_old_ff      <= 1'b0;
      b_old_ff      <= 1'b0;
      actual_pos_ff <= {POS_W{1'b0}};
      edge_ff       <= 1'b0;
    end else begin
      a_sync_ff <= {a_sync_ff[0], enc_a};
      b_sync_ff <= {b_sync_ff[0], enc_b};
      a_old_ff  <= a_now;
      b_old_ff  <= b_now;
      edge_ff   <= moved;
      if (moved) begin
        if (fwd)
          actual_pos_ff <= actual_pos_ff + {{(POS_W-1){1'b0}}, 1'b1};
        else
          actual_pos_ff <= actual_pos_ff - {{(POS_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // pcpl_quad_decoder
`default_nettype wire

// ===== hw/pcpl_top.v
// Pulse command front end, position loop and speed estimate
`timescale 1ns/1ns
`default_nettype none
`include "pcpl_map.vh"
module pcpl_top #(
  parameter POS_W    = `PCPL_POS_W,
  parameter GAIN_W   = `PCPL_GAIN_W,
  parameter VEL_W    = `PCPL_VEL_W,
  parameter SPD_W    = `PCPL_SPD_W,
  parameter POS_DIV  = `PCPL_POS_DIV,
  parameter VEL_DIV  = `PCPL_VEL_DIV
) (
  input  wire                     clk,
  input  wire                     reset,
  input  wire                     mode_select,
  input  wire                     cmd_pulse_a,
  input  wire                     cmd_pulse_b,
  input  wire                     enc_a,
  input  wire                     enc_b,
  input  wire [GAIN_W-1:0]        position_proportional_gain,
  input  wire [VEL_W-1:0]         velocity_limit,
  output reg                      active_mode_ff,
  output reg  signed [POS_W-1:0]  command_pos_ff,
  output reg  signed [POS_W-1:0]  actual_pos_out_ff,
  output reg  signed [POS_W-1:0]  follow_err_ff,
  output reg  signed [VEL_W-1:0]  velocity_cmd_ff,
  output reg                      velocity_cmd_strobe_ff,
  output reg  signed [SPD_W-1:0]  speed_est_ff,
  output reg                      speed_strobe_ff,
  output reg                      vel_tick_ff
);
  localparam PROD_W = POS_W + GAIN_W + 1;
  localparam [31:0] POS_LAST = POS_DIV - 1;
  localparam [31:0] VEL_LAST = VEL_DIV - 1;

  // ==========================================================
  // Mode capture: clocked on the first cycle after reset is released, held until the next reset
  reg mode_seen_ff;
  always @(posedge clk) begin
    if (reset) begin
      mode_seen_ff   <= 1'b0;
      active_mode_ff <= `PCPL_MODE_STEP_DIR;
    end else if (!mode_seen_ff) begin
      mode_seen_ff   <= 1'b1;
      active_mode_ff <= mode_select;
    end
  end

  // ==========================================================
  // Command input synchronisers and edge detect
  reg [1:0] pa_sync_ff;
  reg [1:0] pb_sync_ff;
  reg       pa_old_ff;
  always @(posedge clk) begin
    if (reset) begin
      pa_sync_ff <= 2'b00;
      pb_sync_ff <= 2'b00;
      pa_old_ff  <= 1'b0;
    end else begin
      pa_sync_ff <= {pa_sync_ff[0], cmd_pulse_a};
      pb_sync_ff <= {pb_sync_ff[0], cmd_pulse_b};
      pa_old_ff  <= pa_sync_ff[1];
    end
  end
  reg pb_old_ff;
  always @(posedge clk) begin
    if (reset)
      pb_old_ff <= 1'b0;
    else
      pb_old_ff <= pb_sync_ff[1];
  end
  // Rising edges only, so a clean pulse is counted exactly once
  wire rise_a = pa_sync_ff[1] & ~pa_old_ff;
  wire rise_b = pb_sync_ff[1] & ~pb_old_ff;

  // ==========================================================
  // Command accumulator in encoder count units
  reg signed [POS_W-1:0] nxt_command_pos;
  always @* begin
    nxt_command_pos = command_pos_ff;
    if (active_mode_ff == `PCPL_MODE_STEP_DIR) begin
      // Direction level sampled with the step edge
      if (rise_a && !pb_sync_ff[1])
        nxt_command_pos = command_pos_ff + 1;
      else if (rise_a)
        nxt_command_pos = command_pos_ff - 1;
    end else begin
      // Simultaneous up and down edges cancel out
      if (rise_a && !rise_b)
        nxt_command_pos = command_pos_ff + 1;
      else if (rise_b && !rise_a)
        nxt_command_pos = command_pos_ff - 1;
    end
  end
  always @(posedge clk) begin
    if (reset)
      command_pos_ff <= {POS_W{1'b0}};
    else
      command_pos_ff <= nxt_command_pos;
  end

  // ==========================================================
  // Encoder decoder
  wire [POS_W-1:0] actual_pos;
  wire             enc_edge;
  pcpl_quad_decoder #(
    .POS_W (POS_W)
  ) u_quad (
    .clk           (clk),
    .reset         (reset),
    .enc_a         (enc_a),
    .enc_b         (enc_b),
    .actual_pos_ff (actual_pos),
    .edge_ff       (enc_edge)
  );

  // ==========================================================
  // Continuous following error
  always @(posedge clk) begin
    if (reset) begin
      actual_pos_out_ff <= {POS_W{1'b0}};
      follow_err_ff     <= {POS_W{1'b0}};
    end else begin
      actual_pos_out_ff <= actual_pos;
      follow_err_ff     <= command_pos_ff - $signed(actual_pos);
    end
  end

  // ==========================================================
  // Loop rate dividers; one-cycle enables
  reg [31:0] pos_cnt_ff;
  reg [31:0] vel_cnt_ff;
  wire pos_tick = (pos_cnt_ff == POS_LAST);
  wire vel_tick = (vel_cnt_ff == VEL_LAST);
  always @(posedge clk) begin
    if (reset) begin
      pos_cnt_ff <= 32'h0000_0000;
      vel_cnt_ff <= 32'h0000_0000;
    end else begin
      pos_cnt_ff <= pos_tick ? 32'h0000_0000 : pos_cnt_ff + 32'h0000_0001;
      vel_cnt_ff <= vel_tick ? 32'h0000_0000 : vel_cnt_ff + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Proportional position loop with clamp to the velocity limit
  wire signed [PROD_W-1:0] gain_s  = $signed({1'b0, position_proportional_gain});
  wire signed [PROD_W-1:0] product = follow_err_ff * gain_s;
  wire signed [PROD_W-1:0] lim_pos = $signed({{(PROD_W-VEL_W){1'b0}}, velocity_limit});
  wire signed [PROD_W-1:0] lim_neg = -lim_pos;
  reg  signed [VEL_W-1:0]  nxt_velocity_cmd;
  // Clamp keeps a large error from demanding more than the set top speed
  always @* begin
    if (product > lim_pos)
      nxt_velocity_cmd = lim_pos[VEL_W-1:0];
    else if (product < lim_neg)
      nxt_velocity_cmd = lim_neg[VEL_W-1:0];
    else
      nxt_velocity_cmd = product[VEL_W-1:0];
  end
  // Holding still with zero pulses still runs the loop on the error
  always @(posedge clk) begin
    if (reset) begin
      velocity_cmd_ff        <= {VEL_W{1'b0}};
      velocity_cmd_strobe_ff <= 1'b0;
    end else begin
      velocity_cmd_strobe_ff <= pos_tick;
      if (pos_tick)
        velocity_cmd_ff <= nxt_velocity_cmd;
    end
  end

  // ==========================================================
  // Speed estimate: signed position change per velocity period over edge timing.
  // Takes the net count change per 5 kHz window; low speeds show ripple by design.
  reg signed [SPD_W-1:0] edge_cnt_ff;
  reg signed [POS_W-1:0] last_pos_ff;
  wire signed [POS_W-1:0] pos_delta = $signed(actual_pos) - last_pos_ff;
  always @(posedge clk) begin
    if (reset) begin
      edge_cnt_ff     <= {SPD_W{1'b0}};
      last_pos_ff     <= {POS_W{1'b0}};
      speed_est_ff    <= {SPD_W{1'b0}};
      speed_strobe_ff <= 1'b0;
      vel_tick_ff     <= 1'b0;
    end else begin
      speed_strobe_ff <= vel_tick;
      vel_tick_ff     <= vel_tick;
      if (enc_edge)
        edge_cnt_ff <= edge_cnt_ff + {{(SPD_W-1){1'b0}}, 1'b1};
      if (vel_tick) begin
        speed_est_ff <= pos_delta[SPD_W-1:0];
        last_pos_ff  <= $signed(actual_pos);
        edge_cnt_ff  <= {SPD_W{1'b0}};
      end
    end
  end
endmodule // pcpl_top
`default_nettype wire

// ===== tb/pcpl_checker.sv
// Port checker for the pulse command position loop
`timescale 1ns/1ns
`default_nettype none
module pcpl_checker #(
  parameter POS_DIV = 20,
  parameter VEL_DIV = 10
) (
  input wire               clk,
  input wire               reset,
  input wire        [15:0] position_proportional_gain,
  input wire        [31:0] velocity_limit,
  input wire               active_mode_ff,
  input wire signed [31:0] command_pos_ff,
  input wire signed [31:0] actual_pos_out_ff,
  input wire signed [31:0] follow_err_ff,
  input wire signed [31:0] velocity_cmd_ff,
  input wire               velocity_cmd_strobe_ff,
  input wire               vel_tick_ff
);
  // ========
  // Clamped product and tick spacing
  wire signed [63:0] prod = follow_err_ff * $signed({1'b0, position_proportional_gain});
  wire signed [63:0] lim  = {32'h0000_0000, velocity_limit};
  wire signed [63:0] want = (prod > lim) ? lim : ((prod < -lim) ? -lim : prod);
  reg [15:0] pc_ff;
  reg [15:0] vc_ff;
  reg        ps_ff;
  reg        vs_ff;
  // First tick after reset has no reference, so it is not judged
  always @(posedge clk) begin
    pc_ff <= (reset || velocity_cmd_strobe_ff) ? 16'h0000 : pc_ff + 16'h0001;
    vc_ff <= (reset || vel_tick_ff) ? 16'h0000 : vc_ff + 16'h0001;
    ps_ff <= !reset && (ps_ff || velocity_cmd_strobe_ff);
    vs_ff <= !reset && (vs_ff || vel_tick_ff);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_err_diff: assert property (follow_err_ff == $past(command_pos_ff) - actual_pos_out_ff)
    else $error("following error wrong");
  a_cmd_unit: assert property ($changed(command_pos_ff) |->
    (command_pos_ff - $past(command_pos_ff) == 1) || ($past(command_pos_ff) - command_pos_ff == 1))
    else $error("command moved more than one count");
  a_act_unit: assert property ($changed(actual_pos_out_ff) |->
    (actual_pos_out_ff - $past(actual_pos_out_ff) == 1) ||
    ($past(actual_pos_out_ff) - actual_pos_out_ff == 1)) else $error("actual jumped");
  a_vstb_pulse: assert property (velocity_cmd_strobe_ff |=> !velocity_cmd_strobe_ff)
    else $error("strobe too long");
  a_pos_period: assert property (ps_ff |-> velocity_cmd_strobe_ff == (pc_ff == POS_DIV - 1))
    else $error("position tick spacing wrong");
  a_vel_period: assert property (vs_ff |-> vel_tick_ff == (vc_ff == VEL_DIV - 1))
    else $error("velocity tick spacing wrong");
  a_vcmd_value: assert property (velocity_cmd_strobe_ff |-> velocity_cmd_ff == $past(want[31:0]))
    else $error("velocity command wrong");
  a_vcmd_hold: assert property (!velocity_cmd_strobe_ff |-> $stable(velocity_cmd_ff))
    else $error("velocity command moved off tick");
  a_mode_hold: assert property (!$past(reset, 2) |-> $stable(active_mode_ff))
    else $error("mode changed while running");
endmodule // pcpl_checker
bind pcpl_top pcpl_checker #(.POS_DIV(POS_DIV), .VEL_DIV(VEL_DIV)) chk (.clk, .reset,
  .position_proportional_gain, .velocity_limit, .active_mode_ff, .command_pos_ff,
  .actual_pos_out_ff, .follow_err_ff, .velocity_cmd_ff, .velocity_cmd_strobe_ff, .vel_tick_ff);
`default_nettype wire

// ===== tb/pcpl_ctl_model.sv
// Motion controller model driving the command pulse lines
`timescale 1ns/1ns
`default_nettype none
module pcpl_ctl_model (
  input  wire clk,
  input  wire dual,
  output reg  pulse_a,
  output reg  pulse_b
);
  initial begin
    pulse_a = 1'b0;
    pulse_b = 1'b0;
  end
  // ========
  // One count per call; slow stretches the gaps as a real profile would
  task send(input reg down, input integer slow);
    begin
      @(posedge clk);
      #1 if (!dual) pulse_b = down;
      repeat (3 + slow) @(posedge clk); // direction settles first
      #1 if (dual && down) pulse_b = 1'b1;
      else pulse_a = 1'b1;
      repeat (2) @(posedge clk); // minimum high time
      #1 pulse_a = 1'b0;
      if (dual) pulse_b = 1'b0;
      repeat (2 + slow) @(posedge clk); // rate is ours
    end
  endtask
endmodule // pcpl_ctl_model
`default_nettype wire

// ===== tb/pcpl_top_tb_top.sv
// Self-checking bench for the pulse command position loop
`timescale 1ns/1ns
`default_nettype none
module pcpl_top_tb_top;
  reg clk, reset, mode_select, dual, enc_a, enc_b, d;
  reg [15:0] gain;
  reg [31:0] vlim;
  wire pa, pb, mode, vstb, sstb, vtick;
  wire signed [31:0] cpos, apos, ferr, vcmd;
  wire signed [23:0] spd;
  integer mismatches, n_checks, i, m, w, ph;
  reg signed [31:0] e_cmd, e_act, m_c, m_a, ssum;
  reg signed [63:0] p, l;
  reg signed [31:0] q_cmd[$], q_act[$], q_vel[$];
  pcpl_top #(.POS_DIV(20), .VEL_DIV(10)) uut (.clk(clk), .reset(reset),
    .mode_select(mode_select), .cmd_pulse_a(pa), .cmd_pulse_b(pb), .enc_a(enc_a),
    .enc_b(enc_b), .position_proportional_gain(gain), .velocity_limit(vlim),
    .active_mode_ff(mode), .command_pos_ff(cpos), .actual_pos_out_ff(apos),
    .follow_err_ff(ferr), .velocity_cmd_ff(vcmd), .velocity_cmd_strobe_ff(vstb),
    .speed_est_ff(spd), .speed_strobe_ff(sstb), .vel_tick_ff(vtick));
  pcpl_ctl_model ctl (.clk(clk), .dual(dual), .pulse_a(pa), .pulse_b(pb));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ========
  // Shared tasks
  task check(input string name, input [63:0] seen, input [63:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      if (q_cmd.size() > 0) mismatches = mismatches + 1; // Unanswered notes are failures
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // A leading B counts up; four clocks between edges for the synchroniser
  task enc(input integer s);
    begin
      ph = (ph + s) & 3;
      @(posedge clk);
      #1 {enc_a, enc_b} = (ph == 0) ? 2'h0 : (ph == 1) ? 2'h2 : (ph == 2) ? 2'h3 : 2'h1;
      e_act = e_act + s;
      repeat (3) @(posedge clk);
    end
  endtask
  // Settle, then note the expectation for the next position-loop strobe
  task note;
    begin
      repeat (8) @(posedge clk);
      l = vlim;
      p = (e_cmd - e_act) * $signed({1'b0, gain});
      if (p > l) p = l;
      else if (p < -l) p = -l;
      q_cmd.push_back(e_cmd);
      q_act.push_back(e_act);
      q_vel.push_back(p[31:0]);
      for (w = 0; w < 60 && q_cmd.size() > 0; w = w + 1) @(posedge clk);
      // A full speed window after settling makes the summed deltas final
      repeat (11) @(posedge clk);
      #1 check("speed sum", ssum, e_act);
    end
  endtask
  task do_reset(input reg md);
    begin
      @(posedge clk);
      #1 reset = 1'b1;
      mode_select = md;
      dual = md;
      repeat (3) @(posedge clk);
      #1 reset = 1'b0;
      e_cmd = 0;
      e_act = 0;
      ssum = 0;
      repeat (2) @(posedge clk);
      #1 mode_select = ~md; // Flip after capture; must be ignored
      check("mode", mode, md);
    end
  endtask
  // Monitor: each strobe answers the oldest note
  always @(posedge clk) begin
    if (sstb === 1'b1)
      ssum = ssum + spd;
    if (vstb === 1'b1 && q_cmd.size() > 0) begin
      m_c = q_cmd.pop_front();
      m_a = q_act.pop_front();
      check("command", cpos, m_c);
      check("actual", apos, m_a);
      check("error", ferr, m_c - m_a);
      check("velocity", vcmd, q_vel.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    stop_test;
  end
  initial begin
    mismatches = 0;
    n_checks = 0;
    {reset, mode_select, dual, enc_a, enc_b, d} = 6'h20;
    gain = 16'h0003;
    vlim = 32'h7fff_ffff;
    ph = 0;
    i = $urandom(32'heacd424c);
    for (m = 0; m < 2; m = m + 1) begin
      do_reset(m[0]); // Step mode, then dual pulse mode
      gain = $urandom % 8 + 1;
      vlim = 32'h7fff_ffff;
      note; // All zero after reset
      for (i = 0; i < 12; i = i + 1) begin
        d = $urandom % 2;
        ctl.send(d, (i % 3 == 0) ? 0 : $urandom % 4);
        e_cmd = e_cmd + (d ? -1 : 1);
      end
      note; // position held once pulses stop
      gain = 16'h0100;
      vlim = 32'h0000_0020; // configured top speed caps the command
      repeat (20) enc(1);
      note; // Negative error clamps at minus the limit
      repeat (40) enc(-1);
      note; // Positive error clamps at the limit
    end
    stop_test;
  end
endmodule // pcpl_top_tb_top
`default_nettype wire
